// file: design/fetch_seq_pkg.sv
package fetch_seq_pkg;
  localparam int PC_W = 21;
  localparam int INSTR_W = 16;
  localparam int SREG_W = 8;
  localparam int LATU_W = 5;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  // Build choices for implemented program memory, in bytes
  localparam int unsigned PMEM_32K = 32'h0000_8000;
  localparam int unsigned PMEM_16K = 32'h0000_4000;
  localparam logic [PC_W-1:0] RESET_VECTOR = 21'h00000;
  localparam logic [PC_W-1:0] HIGH_VECTOR = 21'h00008;
  localparam logic [PC_W-1:0] LOW_VECTOR = 21'h00018;
  localparam logic [PC_W-1:0] PC_STEP = 21'h00002;
  localparam logic [INSTR_W-1:0] NOP_WORD = 16'h0000;
  // Register byte offsets
  localparam logic [ADDR_W-1:0] OFF_PC_LOW = 8'h00;
  localparam logic [ADDR_W-1:0] OFF_LATH = 8'h04;
  localparam logic [ADDR_W-1:0] OFF_LATU = 8'h08;
  localparam logic [ADDR_W-1:0] OFF_CTRL = 8'h0C;
  localparam logic [ADDR_W-1:0] OFF_STAT = 8'h10;
  localparam int CTRL_RUN_BIT = 0;
  localparam logic CTRL_RUN_RESET = 1'b1;
  localparam int STAT_PHASE_LSB = 24;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef enum logic [3:0] {
    PHASE_ONE = 4'h1,
    PHASE_TWO = 4'h2,
    PHASE_THREE = 4'h4,
    PHASE_FOUR = 4'h8
  } phase_t;
endpackage

// file: design/program_counter_fetch_sequencer.sv
// Implementation choices: the register addresses and register access over AXI4-Lite.
`timescale 1ns/10ps
// Operation
// [RULE_01] Program counter is 21 bits, 2-Mbyte space.
// [RULE_02] Fetch beyond implemented memory returns zero.
// [RULE_03] Reset fetches 0000h; interrupts vector 0008h/0018h.
// [RULE_04] Implemented memory size is 32K or 16K.
// [RULE_05] One-deep shadow stack, invisible to software.
// [RULE_06] Interrupt entry saves status, working, bank.
// [RULE_07] Fast return restores the three registers.
// [RULE_08] High interrupt overwrites low interrupt's shadow.
// [RULE_09] Fast call saves; fast return restores.
// [RULE_10] Counter low byte is software readable, writable.
// [RULE_11] Bits 15:8, 20:16 hidden, loaded via latches; the STAT read returns all 21 counter bits.
// [RULE_12] Counter bit 0 is always zero.
// [RULE_13] Sequential execution advances by two.
// [RULE_14] Calls, gotos, branches load directly, no latches.
// [RULE_15] Low byte write copies latches into counter.
// [RULE_16] Low byte read copies counter into latches.
// [RULE_17] Clock divided by four into ordered phases.
// [RULE_18] Increment in phase one; fetch in four.
// [RULE_19] Latched instruction executes in following cycle.
// [RULE_20] Upper latch keeps five bits; rest read zero.
module program_counter_fetch_sequencer
  import fetch_seq_pkg::*;
#(
  parameter int unsigned PMEM_BYTES = PMEM_32K
) (
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [DATA_W-1:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [DATA_W-1:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic [PC_W-1:0] pmem_addr,
  output logic pmem_rd,
  input wire logic [INSTR_W-1:0] pmem_rdata,
  input wire logic irq_high_req,
  input wire logic irq_low_req,
  output logic irq_ack,
  output logic irq_ack_high,
  input wire logic branch_req,
  input wire logic [PC_W-1:0] branch_target,
  input wire logic fast_save,
  input wire logic fast_return,
  input wire logic [SREG_W-1:0] status_in,
  input wire logic [SREG_W-1:0] working_in,
  input wire logic [SREG_W-1:0] bank_in,
  output logic restore_valid,
  output logic [SREG_W-1:0] restore_status,
  output logic [SREG_W-1:0] restore_working,
  output logic [SREG_W-1:0] restore_bank,
  output logic [INSTR_W-1:0] exec_instr,
  output logic exec_valid,
  output phase_t phase
);

  if (PMEM_BYTES != PMEM_32K && PMEM_BYTES != PMEM_16K) begin : g_bad_size
    $error("PMEM_BYTES must be 32 Kbytes or 16 Kbytes"); // [RULE_04]
  end

  function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] off);
    return a == off;
  endfunction

  logic [1:0] rst_sync_q;
  logic rst_n;
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      rst_sync_q <= 2'h0;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_q[1];

  phase_t phase_q, phase_d;
  logic run_q;
  logic [PC_W-1:0] pc_q, pc_d, fetch_addr_q;
  logic [7:0] lath_q, lath_d;
  logic [LATU_W-1:0] latu_q, latu_d;
  logic [INSTR_W-1:0] instr_q;
  logic instr_valid_q;
  logic [SREG_W-1:0] sh_status_q, sh_working_q, sh_bank_q;
  logic restore_valid_q;
  logic bvalid_q, rvalid_q;
  logic [1:0] bresp_q, rresp_q;
  logic [DATA_W-1:0] rdata_q;

  // Bus decode
  wire wr_go = s_axi_awvalid & s_axi_wvalid & ~bvalid_q;
  wire rd_go = s_axi_arvalid & ~rvalid_q;
  wire wr_lane = wr_go & s_axi_wstrb[0];
  wire wr_pc_low = wr_lane & hit(s_axi_awaddr, OFF_PC_LOW);
  wire wr_lath = wr_lane & hit(s_axi_awaddr, OFF_LATH);
  wire wr_latu = wr_lane & hit(s_axi_awaddr, OFF_LATU);
  wire wr_ctrl = wr_lane & hit(s_axi_awaddr, OFF_CTRL);
  wire wr_known = hit(s_axi_awaddr, OFF_PC_LOW) | hit(s_axi_awaddr, OFF_LATH)
                | hit(s_axi_awaddr, OFF_LATU) | hit(s_axi_awaddr, OFF_CTRL)
                | hit(s_axi_awaddr, OFF_STAT);
  wire rd_pc_low = rd_go & hit(s_axi_araddr, OFF_PC_LOW);
  wire rd_known = hit(s_axi_araddr, OFF_PC_LOW) | hit(s_axi_araddr, OFF_LATH)
                | hit(s_axi_araddr, OFF_LATU) | hit(s_axi_araddr, OFF_CTRL)
                | hit(s_axi_araddr, OFF_STAT);
  wire [DATA_W-1:0] rd_mux =
      hit(s_axi_araddr, OFF_PC_LOW) ? {24'h000000, pc_q[7:0]} : // [RULE_10]
      hit(s_axi_araddr, OFF_LATH) ? {24'h000000, lath_q} :
      hit(s_axi_araddr, OFF_LATU) ? {27'h0000000, latu_q} : // [RULE_20]
      hit(s_axi_araddr, OFF_CTRL) ? {31'h00000000, run_q} :
      hit(s_axi_araddr, OFF_STAT) ? {4'h0, phase_q, 3'h0, pc_q} :
      32'h00000000;

  // Sequencer events
  wire ph1 = run_q & (phase_q == PHASE_ONE);
  wire ph4 = run_q & (phase_q == PHASE_FOUR);
  wire take_branch = ph4 & branch_req & ~wr_pc_low;
  wire irq_any = irq_high_req | irq_low_req;
  wire irq_take = ph4 & irq_any & ~branch_req & ~wr_pc_low;
  wire [PC_W-1:0] irq_vec = irq_high_req ? HIGH_VECTOR : LOW_VECTOR;
  wire shadow_save = irq_take | (take_branch & fast_save); // [RULE_06] [RULE_09]
  wire in_range = fetch_addr_q < PC_W'(PMEM_BYTES);
  // Beyond implemented memory the fetch reads as a no-operation word
  wire [INSTR_W-1:0] fetch_word = in_range ? pmem_rdata : NOP_WORD; // [RULE_02]

  always_comb begin
    case (phase_q)
      PHASE_ONE: phase_d = PHASE_TWO;
      PHASE_TWO: phase_d = PHASE_THREE;
      PHASE_THREE: phase_d = PHASE_FOUR;
      PHASE_FOUR: phase_d = PHASE_ONE;
      default: phase_d = PHASE_ONE;
    endcase
  end

  // A software write of the low byte outranks every core redirect
  always_comb begin
    if (wr_pc_low) begin
      pc_d = {latu_q, lath_q, s_axi_wdata[7:1], 1'b0}; // [RULE_15] [RULE_11]
    end else if (take_branch) begin
      pc_d = {branch_target[PC_W-1:1], 1'b0}; // [RULE_14]
    end else if (irq_take) begin
      pc_d = irq_vec; // [RULE_03]
    end else if (ph1) begin
      pc_d = pc_q + PC_STEP; // [RULE_13] [RULE_01]
    end else begin
      pc_d = pc_q;
    end
  end

  // Read copy wins over a same-cycle latch write
  assign lath_d = rd_pc_low ? pc_q[15:8] : (wr_lath ? s_axi_wdata[7:0] : lath_q); // [RULE_16]
  assign latu_d = rd_pc_low ? pc_q[20:16] : (wr_latu ? s_axi_wdata[LATU_W-1:0] : latu_q);

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      phase_q <= PHASE_ONE;
      run_q <= CTRL_RUN_RESET;
      pc_q <= RESET_VECTOR; // [RULE_03]
      lath_q <= 8'h00;
      latu_q <= 5'h00;
    end else begin
      phase_q <= run_q ? phase_d : phase_q; // [RULE_17]
      run_q <= wr_ctrl ? s_axi_wdata[CTRL_RUN_BIT] : run_q;
      pc_q <= {pc_d[PC_W-1:1], 1'b0}; // [RULE_12]
      lath_q <= lath_d;
      latu_q <= latu_d;
    end
  end

  // Address is taken at the end of phase one so memory has three cycles to answer
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      fetch_addr_q <= RESET_VECTOR;
      instr_q <= NOP_WORD;
      instr_valid_q <= 1'b0;
    end else begin
      if (ph1) begin
        fetch_addr_q <= pc_q; // [RULE_18]
      end
      if (ph4) begin
        instr_q <= fetch_word; // [RULE_18] [RULE_19]
        instr_valid_q <= ~(take_branch | irq_take | wr_pc_low);
      end
    end
  end

  // Shadow copy has no port toward software and no nesting guard
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      sh_status_q <= 8'h00;
      sh_working_q <= 8'h00;
      sh_bank_q <= 8'h00;
      restore_valid_q <= 1'b0;
    end else begin
      if (shadow_save) begin
        sh_status_q <= status_in; // [RULE_05] [RULE_08]
        sh_working_q <= working_in;
        sh_bank_q <= bank_in;
      end
      restore_valid_q <= ph4 & fast_return; // [RULE_07]
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      bvalid_q <= 1'b0;
      bresp_q <= RESP_OKAY;
      rvalid_q <= 1'b0;
      rresp_q <= RESP_OKAY;
      rdata_q <= 32'h00000000;
    end else begin
      if (wr_go) begin
        bvalid_q <= 1'b1;
        bresp_q <= wr_known ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bready) begin
        bvalid_q <= 1'b0;
      end
      if (rd_go) begin
        rvalid_q <= 1'b1;
        rresp_q <= rd_known ? RESP_OKAY : RESP_SLVERR;
        rdata_q <= rd_mux;
      end else if (s_axi_rready) begin
        rvalid_q <= 1'b0;
      end
    end
  end

  assign s_axi_awready = wr_go;
  assign s_axi_wready = wr_go;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_arready = rd_go;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rresp = rresp_q;
  assign s_axi_rdata = rdata_q;
  assign pmem_addr = fetch_addr_q;
  assign pmem_rd = ph4;
  assign irq_ack = irq_take;
  assign irq_ack_high = irq_take & irq_high_req;
  assign restore_valid = restore_valid_q;
  assign restore_status = sh_status_q;
  assign restore_working = sh_working_q;
  assign restore_bank = sh_bank_q;
  assign exec_instr = instr_q;
  assign exec_valid = instr_valid_q;
  assign phase = phase_q;

  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rst_n);

  sequence s_fetch_load;
    ph4 ##1 1'b1;
  endsequence

  sequence s_instr_held;
    $stable(instr_q) [*3];
  endsequence

  a_pc_align: assert property (pc_q[0] == 1'b0) // [RULE_12]
    else $error("program counter bit 0 not zero");

  a_phase_order: assert property (ph1 |=> (phase_q == PHASE_TWO) ##1 (phase_q == PHASE_THREE)
    ##1 (phase_q == PHASE_FOUR) ##1 (phase_q == PHASE_ONE)) // [RULE_17]
    else $error("phase sequence out of order");

  a_pc_step: assert property (ph1 && !wr_pc_low |=> pc_q == $past(pc_q) + PC_STEP) // [RULE_13]
    else $error("counter did not advance by two in phase one");

  a_zero_fill: assert property (ph4 && !in_range |=> instr_q == NOP_WORD) // [RULE_02]
    else $error("fetch outside memory not zero");

  // The load edge itself changes the word, so holding is checked from the next tick
  a_instr_exec: assert property (s_fetch_load |=> s_instr_held) // [RULE_19]
    else $error("instruction changed during execute cycle");

  a_irq_vector: assert property (irq_take |=> pc_q == $past(irq_vec)
    && ($past(irq_high_req) ? pc_q == HIGH_VECTOR : pc_q == LOW_VECTOR)) // [RULE_03]
    else $error("interrupt did not load its vector");

  a_shadow_save: assert property (irq_take |=> sh_status_q == $past(status_in)
    && sh_working_q == $past(working_in) && sh_bank_q == $past(bank_in)) // [RULE_06]
    else $error("shadow not loaded on interrupt");

  a_fast_call: assert property (take_branch && fast_save |=> sh_bank_q == $past(bank_in)
    && pc_q == {$past(branch_target[PC_W-1:1]), 1'b0}) // [RULE_09]
    else $error("fast call did not save shadow or jump");

  a_fast_ret: assert property (ph4 && fast_return && !shadow_save |=> restore_valid
    && restore_status == $past(sh_status_q) ##1 !restore_valid) // [RULE_07]
    else $error("fast return restore wrong");

  a_low_write: assert property (wr_pc_low |=> pc_q[20:8] == {$past(latu_q), $past(lath_q)}
    && pc_q[7:1] == $past(s_axi_wdata[7:1])) // [RULE_15]
    else $error("low byte write did not merge latches");

  a_low_read: assert property (rd_pc_low |=> lath_q == $past(pc_q[15:8])
    && latu_q == $past(pc_q[20:16]) && s_axi_rdata[7:0] == $past(pc_q[7:0])) // [RULE_16]
    else $error("low byte read did not capture upper bytes");

  a_latu_width: assert property (s_axi_rvalid && $past(rd_go)
    && $past(hit(s_axi_araddr, OFF_LATU)) |-> s_axi_rdata[31:LATU_W] == 27'h0) // [RULE_20]
    else $error("upper latch unused bits not zero");

  a_write_answer: assert property (s_axi_awready |=> s_axi_bvalid)
    else $error("write response did not follow take");

  a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready
    |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped before ready");

  a_read_answer: assert property (s_axi_arready |=> s_axi_rvalid)
    else $error("read data did not follow take");

  a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready
    |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped before ready");

  a_fetch_addr: assert property (ph1 |=> pmem_addr == $past(pc_q)) // [RULE_18]
    else $error("fetch address not taken in phase one");

  a_fetch_strobe: assert property (pmem_rd |-> phase_q == PHASE_FOUR) // [RULE_18]
    else $error("fetch strobe outside phase four");

  a_range_pass: assert property (ph4 && in_range |=> instr_q == $past(pmem_rdata)) // [RULE_02]
    else $error("implemented memory word not latched");

  a_direct_load: assert property (take_branch
    |=> pc_q == {$past(branch_target[PC_W-1:1]), 1'b0}) // [RULE_14]
    else $error("branch did not load target directly");

  a_flush_slot: assert property (ph4 && (take_branch || irq_take || wr_pc_low)
    |=> !exec_valid) // [RULE_19]
    else $error("redirected slot not flushed");

  // Nothing guards the low priority copy, so a high entry must simply overwrite it
  a_high_over: assert property (irq_take && irq_high_req
    |=> sh_status_q == $past(status_in) && sh_bank_q == $past(bank_in)) // [RULE_08]
    else $error("high interrupt did not overwrite shadow");

  a_shadow_keep: assert property (!shadow_save |=> $stable(sh_status_q)
    && $stable(sh_working_q) && $stable(sh_bank_q)) // [RULE_05]
    else $error("shadow changed without a save");

  a_latch_keep: assert property (!rd_pc_low && !wr_lath && !wr_latu
    |=> $stable(lath_q) && $stable(latu_q)) // [RULE_11]
    else $error("latch changed without access");

  a_ack_pair: assert property (irq_ack_high |-> irq_ack && ph4) // [RULE_03]
    else $error("high acknowledge without interrupt entry");

  a_run_freeze: assert property (!run_q && !wr_pc_low
    |=> $stable(pc_q) && $stable(phase_q)) // [RULE_17]
    else $error("stopped sequencer moved");

endmodule // program_counter_fetch_sequencer

// file: tb/fetch_partner_model.sv
`timescale 1ns/10ps
module fetch_partner_model
  import fetch_seq_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic [PC_W-1:0] pmem_addr,
  input wire logic pmem_rd,
  output logic [INSTR_W-1:0] pmem_rdata,
  input wire logic fire_high,
  input wire logic fire_low,
  input wire logic irq_ack,
  input wire logic irq_ack_high,
  output logic irq_high_req,
  output logic irq_low_req
);
  logic [INSTR_W-1:0] word;
  assign word = pmem_addr[16:1] ^ 16'h5A3C;
  // Outside the read slot the bus shows the inverse, so a mistimed sample is caught
  assign pmem_rdata = pmem_rd ? word : ~word;
  // Requests stay up as levels until the core acknowledges their priority
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      irq_high_req <= 1'b0;
      irq_low_req <= 1'b0;
    end else begin
      irq_high_req <= fire_high | (irq_high_req & ~(irq_ack & irq_ack_high));
      irq_low_req <= fire_low | (irq_low_req & ~(irq_ack & ~irq_ack_high));
    end
  end
endmodule // fetch_partner_model

// file: tb/program_counter_fetch_sequencer_tb.sv
`timescale 1ns/10ps
module program_counter_fetch_sequencer_tb
  import fetch_seq_pkg::*;
;
  localparam logic [15:0] PAT = 16'h5A3C;
  logic ref_clk = 1'b0;
  logic rstn = 1'b0;
  logic [ADDR_W-1:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic [DATA_W-1:0] s_axi_wdata = 32'h0, s_axi_rdata, rd;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, pmem_rd;
  logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
  logic [PC_W-1:0] pmem_addr, branch_target = 21'h0;
  logic [INSTR_W-1:0] pmem_rdata, exec_instr;
  logic irq_high_req, irq_low_req, irq_ack, irq_ack_high, restore_valid, exec_valid;
  logic branch_req = 1'b0, fast_save = 1'b0, fast_return = 1'b0;
  logic fire_high = 1'b0, fire_low = 1'b0;
  logic [SREG_W-1:0] status_in = 8'h0, working_in = 8'h0, bank_in = 8'h0;
  logic [SREG_W-1:0] restore_status, restore_working, restore_bank;
  logic [3:0] ph = 4'h1;
  phase_t phase;
  int n_mismatch = 0;
  int checked = 0;

  always #2 ref_clk = ~ref_clk;

  program_counter_fetch_sequencer #(.PMEM_BYTES(PMEM_16K)) u_program_counter_fetch_sequencer (
    .ref_clk, .rstn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .pmem_addr, .pmem_rd, .pmem_rdata, .irq_high_req, .irq_low_req, .irq_ack,
    .irq_ack_high, .branch_req, .branch_target, .fast_save, .fast_return, .status_in,
    .working_in, .bank_in, .restore_valid, .restore_status, .restore_working, .restore_bank,
    .exec_instr, .exec_valid, .phase);

  fetch_partner_model u_fetch_partner_model (.ref_clk, .rstn, .pmem_addr, .pmem_rd,
    .pmem_rdata, .fire_high, .fire_low, .irq_ack, .irq_ack_high, .irq_high_req, .irq_low_req);

  task automatic conclude();
    if (n_mismatch == 0 && checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  task automatic cmp_data(input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) begin
      n_mismatch++;
      $display("mismatch t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask

  task automatic cmp_addr(input logic [PC_W-1:0] e);
    checked++;
    if (pmem_addr !== e) begin
      n_mismatch++;
      $display("mismatch t=%0t exp=%h got=%h", $time, e, pmem_addr);
    end
  endtask

  task automatic wait_phase(input phase_t p);
    for (int i = 0; i < 8; i++) begin
      @(posedge ref_clk);
      #1;
      if (phase === p) break;
    end
  endtask

  // Sampled at the falling edge so the handshake seen is the one the next rising edge takes
  task automatic wait_hi(ref logic s);
    for (int i = 0; i < 50; i++) begin
      @(negedge ref_clk);
      if (s === 1'b1) break;
    end
  endtask

  task automatic axi_write(input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    wait_hi(s_axi_awready);
    @(posedge ref_clk);
    s_axi_awvalid <= 1'b0;
    s_axi_wvalid <= 1'b0;
    wait_hi(s_axi_bvalid);
    rsp = s_axi_bresp;
    @(posedge ref_clk);
    s_axi_bready <= 1'b0;
  endtask

  task automatic axi_read(input logic [7:0] a);
    @(posedge ref_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    wait_hi(s_axi_arready);
    @(posedge ref_clk);
    s_axi_arvalid <= 1'b0;
    wait_hi(s_axi_rvalid);
    rd = s_axi_rdata;
    rsp = s_axi_rresp;
    @(posedge ref_clk);
    s_axi_rready <= 1'b0;
  endtask

  // Core requests are held across the whole phase-four cycle, as the core would
  task automatic core_p4(input logic br, input logic fs, input logic fr, input logic [20:0] t);
    wait_phase(PHASE_THREE);
    @(posedge ref_clk);
    {branch_req, fast_save, fast_return, branch_target} <= {br, fs, fr, t};
    @(posedge ref_clk);
    {branch_req, fast_save, fast_return} <= 3'h0;
  endtask

  task automatic branch_chk(input logic [20:0] t, input logic fs, input logic [15:0] e);
    core_p4(1'b1, fs, 1'b0, t);
    wait_phase(PHASE_FOUR);
    cmp_addr({t[20:1], 1'b0});
    wait_phase(PHASE_ONE);
    cmp_data(32'(e), 32'(exec_instr));
    cmp_data(32'h1, 32'(exec_valid));
  endtask

  task automatic irq(input logic hi, input logic [23:0] v, input logic [20:0] vec);
    wait_phase(PHASE_ONE);
    @(posedge ref_clk);
    {fire_high, fire_low, status_in, working_in, bank_in} <= {hi, ~hi, v};
    @(posedge ref_clk);
    {fire_high, fire_low} <= 2'h0;
    wait_phase(PHASE_ONE);
    wait_phase(PHASE_FOUR);
    cmp_addr(vec);
    cmp_data(32'(v), 32'({restore_status, restore_working, restore_bank}));
  endtask

  initial begin
    repeat (12) @(posedge ref_clk);
    rstn <= 1'b1;
    repeat (3) @(posedge ref_clk);
    wait_phase(PHASE_FOUR);
    cmp_addr(RESET_VECTOR);
    for (int i = 0; i < 4; i++) begin
      @(posedge ref_clk);
      #1;
      cmp_data(32'(ph), 32'(phase));
      if (i == 0) cmp_data(32'(PAT), 32'(exec_instr));
      ph = {ph[2:0], ph[3]};
    end
    cmp_addr(PC_STEP);
    axi_read(OFF_CTRL);
    cmp_data(32'h1, rd);
    axi_read(8'h14);
    cmp_data(32'(RESP_SLVERR), 32'(rsp));
    cmp_data(32'h0, rd);
    axi_write(OFF_LATU, 32'hFF);
    cmp_data(32'(RESP_OKAY), 32'(rsp));
    axi_read(OFF_LATU);
    cmp_data(32'h1F, rd);
    axi_write(OFF_LATH, 32'h12);
    wait_phase(PHASE_TWO);
    axi_write(OFF_PC_LOW, 32'h35);
    wait_phase(PHASE_FOUR);
    cmp_addr(21'h1F1234);
    axi_write(OFF_LATH, 32'h0);
    axi_write(OFF_LATU, 32'h0);
    axi_read(OFF_PC_LOW);
    cmp_data(32'h0, rd & 32'hFFFFFF01);
    axi_read(OFF_LATH);
    cmp_data(32'h12, rd);
    axi_read(OFF_LATU);
    cmp_data(32'h1F, rd);
    branch_chk(21'h00101, 1'b0, PAT ^ 16'h0080);
    branch_chk(21'h03FFE, 1'b0, PAT ^ 16'h1FFF);
    branch_chk(21'h04000, 1'b0, NOP_WORD);
    branch_chk(21'h1FFFFE, 1'b0, NOP_WORD);
    @(posedge ref_clk);
    {status_in, working_in, bank_in} <= 24'h112233;
    branch_chk(21'h00200, 1'b1, PAT ^ 16'h0100);
    cmp_data(32'h112233, 32'({restore_status, restore_working, restore_bank}));
    irq(1'b0, 24'h445566, LOW_VECTOR);
    irq(1'b1, 24'h778899, HIGH_VECTOR);
    @(posedge ref_clk);
    {status_in, working_in, bank_in} <= 24'hAABBCC;
    core_p4(1'b0, 1'b0, 1'b1, 21'h0);
    #1;
    cmp_data(32'h1, 32'(restore_valid));
    cmp_data(32'h778899, 32'({restore_status, restore_working, restore_bank}));
    @(posedge ref_clk);
    #1;
    cmp_data(32'h0, 32'(restore_valid));
    conclude();
  end

  // The sequence needs well under a thousand cycles; this margin only catches a hang
  initial begin
    #20000;
    n_mismatch++;
    conclude();
  end
endmodule // program_counter_fetch_sequencer_tb
